// ### dram_channel_checker.sv
// Checker for the channel data path; watches the channel top's ports only.
// Assumes one channel and mode pins that change only while no burst runs.
`include "dram_channel_regs.vh"

module dram_channel_checker #(
  parameter CHANNELS = 1
) (
  input wire clk,
  input wire rst_n,
  input wire dieReset_n,
  input wire scanEnablePin,
  input wire [CHANNELS-1:0] inversionEnable,
  input wire [CHANNELS-1:0] maskMode,
  input wire [CHANNELS*`DCH_DQ_W-1:0] dqOut,
  input wire [CHANNELS*`DCH_LANES-1:0] dqOe,
  input wire [CHANNELS*`DCH_LANES-1:0] dqsTrueOut,
  input wire [CHANNELS*`DCH_LANES-1:0] dqsCompOut,
  input wire [CHANNELS*`DCH_LANES-1:0] dqsOe,
  input wire [CHANNELS*`DCH_LANES-1:0] maskInvertOut,
  input wire [CHANNELS*`DCH_LANES-1:0] maskInvertOe,
  input wire scanActive
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] togCnt_ff;
  reg lastTrue_ff;

  // Strobe toggles of lane 0 in the current burst; cleared while the lane is released
  always @(posedge clk) begin
    if (!rst_n || !dqsOe[0]) begin
      togCnt_ff <= 4'h0;
    end else if (dqsTrueOut[0] != lastTrue_ff) begin
      togCnt_ff <= togCnt_ff + 4'h1;
    end
    lastTrue_ff <= dqsTrueOut[0];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // One enable flop drives data, strobe and flag of a lane
  chk_enables_shared: assert property (dqOe == dqsOe
    && dqOe == maskInvertOe)
    else $error("lane enables disagree");
  chk_reset_outputs: assert property (disable iff (1'b0) !rst_n |=> dqOe == '0 &&
    dqsTrueOut == '0 && dqsCompOut == '1 && scanActive == 1'b0)
    else $error("outputs not at reset values");
  chk_die_reset: assert property ((!dieReset_n) [*8] |-> dqOe == '0 && dqOut == '0)
    else $error("die reset did not release the lanes");
  chk_read_preamble: assert property ($rose(dqsOe[0]) |->
    !dqsTrueOut[0] && dqsCompOut[0])
    else $error("read strobe preamble wrong");
  chk_strobe_pair: assert property (dqsOe[0] && dqsOe[1] |->
    dqsCompOut == ~dqsTrueOut)
    else $error("strobe legs not complementary");
  chk_data_with_strobe: assert property (dqOe[0] && $past(dqOe[0]) &&
    dqOut[7:0] != $past(dqOut[7:0]) |-> dqsTrueOut[0] != $past(dqsTrueOut[0]))
    else $error("read data moved without a strobe edge");
  chk_eight_beats: assert property ($fell(dqsOe[0]) |-> togCnt_ff == 4'h8)
    else $error("read burst without eight strobe edges");
  chk_flag_inverted: assert property (maskInvertOe[0] &&
    maskInvertOut[0] |-> $countones(dqOut[7:0]) < 4 && inversionEnable[0] && !maskMode[0])
    else $error("flag high on a byte that is not inverted");
  chk_flag_plain: assert property (maskInvertOe[0] && !maskInvertOut[0] &&
    inversionEnable[0] && !maskMode[0] |-> $countones(dqOut[7:0]) <= 4)
    else $error("heavy byte sent without inversion");
  chk_scan_follow: assert property ($rose(scanEnablePin) |-> ##[1:8] scanActive)
    else $error("scan enable not followed");
  chk_scan_release: assert property (scanActive [*3] |->
    dqOe == '0 && dqsOe == '0)
    else $error("lanes driven during scan");
endmodule // dram_channel_checker

// ### dram_channel_data_address.v
// Data path and addressing of a low-power DDR die, one block per channel.
// Assumes every pin is asynchronous to clk and the link clock is far slower
// than clk; commands arrive already decoded as activate/read/write strobes.
`include "dram_channel_regs.vh"

// Operation
// - Device drives strobe pair aligned with read data.
// - Each byte lane has its own strobe pair.
// - Every channel keeps separate strobes.
// - Flag high for inverted byte, low otherwise.
// - Inversion can be switched off.
// - Mask line blocks storing masked write bytes.
// - Mode chooses mask or inversion meaning.
// - Die reset pin resets all channels.
// - Scan enable high selects scan function.
// - Eight banks, 14 row, 10 column bits.
// - Two low column bits are always zero.
// - Second channel exists only on dual variants.
// - Commands sampled at true-rise/complement-fall crossing.
// - Two beats per clock, eight per access.
module dram_channel_data_address #(
  parameter CHANNELS = 1,
  parameter ROW_KEEP = 2
) (
  input wire clk,
  input wire rst_n,
  input wire dieReset_n,
  input wire scanEnablePin,
  input wire [CHANNELS-1:0] clockTrue,
  input wire [CHANNELS-1:0] clockComplement,
  input wire [CHANNELS-1:0] cmdActivate,
  input wire [CHANNELS-1:0] cmdRead,
  input wire [CHANNELS-1:0] cmdWrite,
  input wire [CHANNELS*`DCH_BANK_W-1:0] bankSelectBits,
  input wire [CHANNELS*`DCH_ROW_W-1:0] rowSelectBits,
  input wire [CHANNELS*`DCH_COLSENT_W-1:0] columnSelectBits,
  input wire [CHANNELS-1:0] inversionEnable,
  input wire [CHANNELS-1:0] maskMode,
  input wire [CHANNELS*`DCH_DQ_W-1:0] dqIn,
  output wire [CHANNELS*`DCH_DQ_W-1:0] dqOut,
  output wire [CHANNELS*`DCH_LANES-1:0] dqOe,
  input wire [CHANNELS*`DCH_LANES-1:0] dqsTrueIn,
  input wire [CHANNELS*`DCH_LANES-1:0] dqsCompIn,
  output wire [CHANNELS*`DCH_LANES-1:0] dqsTrueOut,
  output wire [CHANNELS*`DCH_LANES-1:0] dqsCompOut,
  output wire [CHANNELS*`DCH_LANES-1:0] dqsOe,
  input wire [CHANNELS*`DCH_LANES-1:0] maskInvertIn,
  output wire [CHANNELS*`DCH_LANES-1:0] maskInvertOut,
  output wire [CHANNELS*`DCH_LANES-1:0] maskInvertOe,
  output wire scanActive
);

  // Storage index: bank, retained row bits, full column
  localparam AW = `DCH_BANK_W + ROW_KEEP + `DCH_COL_W;
  localparam SW = 5 + `DCH_BANK_W + `DCH_ROW_W + `DCH_COLSENT_W + 2 + `DCH_DQ_W
    + 3 * `DCH_LANES;
  localparam [1:0] ST_IDLE = `DCH_ST_IDLE;
  localparam [1:0] ST_READ = `DCH_ST_READ;
  localparam [1:0] ST_WRITE = `DCH_ST_WRITE;

  // Die-wide pins: one reset and one scan enable shared by all channels
  wire [1:0] globalF;
  dram_pin_sync #(
    .WIDTH(2),
    .INIT(2'h0)
  ) u_globalSync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn({dieReset_n, scanEnablePin}),
    .pinOut(globalF)
  );

  // Reset pin low holds every channel in reset together
  wire chRst = !rst_n || !globalF[1];
  wire scanF = globalF[0];

  // Scan mode flag; a grounded or floating pin keeps normal operation
  reg scanActive_ff;
  always @(posedge clk) begin
    if (chRst) begin
      scanActive_ff <= 1'b0;
    end else begin
      scanActive_ff <= scanF;
    end
  end
  assign scanActive = scanActive_ff;

  genvar c;
  genvar l;
  generate
    // Channel count is a build choice: the second channel only on dual dies
    for (c = 0; c < CHANNELS; c = c + 1) begin : chan
      wire [SW-1:0] pinF;
      wire ckT;
      wire ckC;
      wire cAct;
      wire cRd;
      wire cWr;
      wire [`DCH_BANK_W-1:0] cBank;
      wire [`DCH_ROW_W-1:0] cRow;
      wire [`DCH_COLSENT_W-1:0] cCol;
      wire invF;
      wire maskF;
      wire [`DCH_DQ_W-1:0] dqF;
      wire [`DCH_LANES-1:0] dqsTF;
      wire [`DCH_LANES-1:0] dqsCF;
      wire [`DCH_LANES-1:0] dmiF;
      wire [`DCH_LANES-1:0] laneDone;

      // All channel pins share one synchroniser bank
      dram_pin_sync #(
        .WIDTH(SW),
        .INIT({SW{1'b0}})
      ) u_pinSync (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn({clockTrue[c], clockComplement[c], cmdActivate[c], cmdRead[c],
          cmdWrite[c], bankSelectBits[c*`DCH_BANK_W +: `DCH_BANK_W],
          rowSelectBits[c*`DCH_ROW_W +: `DCH_ROW_W],
          columnSelectBits[c*`DCH_COLSENT_W +: `DCH_COLSENT_W],
          inversionEnable[c], maskMode[c], dqIn[c*`DCH_DQ_W +: `DCH_DQ_W],
          dqsTrueIn[c*`DCH_LANES +: `DCH_LANES],
          dqsCompIn[c*`DCH_LANES +: `DCH_LANES],
          maskInvertIn[c*`DCH_LANES +: `DCH_LANES]}),
        .pinOut(pinF)
      );
      assign {ckT, ckC, cAct, cRd, cWr, cBank, cRow, cCol, invF, maskF, dqF,
        dqsTF, dqsCF, dmiF} = pinF;

      // Differential clock level counts only while the two legs differ,
      // so a leg that settles a cycle late causes no false edge
      reg ckLvl_ff;
      wire ckPair = ckT ^ ckC;
      wire ckEdge = ckPair && (ckT != ckLvl_ff);
      wire crossing = ckEdge && ckT;
      always @(posedge clk) begin
        if (chRst) begin
          ckLvl_ff <= 1'b0;
        end else if (ckPair) begin
          ckLvl_ff <= ckT;
        end
      end

      reg [1:0] state_ff;
      reg [3:0] beat_ff;
      reg [4:0] guard_ff;
      reg [`DCH_BANK_W-1:0] bank_ff;
      reg [`DCH_COL_W-1:0] col_ff;
      reg [`DCH_ROW_W-1:0] openRow_ff [0:`DCH_BANKS-1];
      integer i;

      wire startAcc = (state_ff == ST_IDLE) && crossing && (cRd || cWr) && !scanF;
      wire startRead = startAcc && cRd;
      wire rdStep = (state_ff == ST_READ) && ckEdge && (beat_ff != `DCH_BEATS);
      wire rdEnd = (state_ff == ST_READ) && ckEdge && (beat_ff == `DCH_BEATS);
      wire [ROW_KEEP-1:0] rowSel = openRow_ff[bank_ff][ROW_KEEP-1:0];
      wire [`DCH_COL_W-1:0] rdCol = col_ff + {7'h00, beat_ff[`DCH_BEAT_W-1:0]};
      wire [AW-1:0] rdAddr = {bank_ff, rowSel, rdCol};

      // Activate records the row per bank; read and write use it later
      always @(posedge clk) begin
        if (chRst) begin
          for (i = 0; i < `DCH_BANKS; i = i + 1) begin
            openRow_ff[i] <= {`DCH_ROW_W{1'b0}};
          end
        end else if (crossing && cAct && !scanF) begin
          openRow_ff[cBank] <= cRow;
        end
      end

      // Burst sequencer; read wins if both strobes come in one crossing
      always @(posedge clk) begin
        if (chRst) begin
          state_ff <= ST_IDLE;
          beat_ff <= 4'h0;
          guard_ff <= 5'h00;
          bank_ff <= {`DCH_BANK_W{1'b0}};
          col_ff <= {`DCH_COL_W{1'b0}};
        end else if (scanF) begin
          state_ff <= ST_IDLE;
        end else begin
          case (state_ff)
            ST_IDLE: begin
              if (startAcc) begin
                bank_ff <= cBank;
                col_ff <= {cCol, `DCH_COL_ZERO};
                beat_ff <= 4'h0;
                guard_ff <= 5'h00;
                state_ff <= cRd ? ST_READ : ST_WRITE;
              end
            end
            ST_READ: begin
              // Each clock half-cycle moves one beat, eight per access
              if (rdEnd) begin
                state_ff <= ST_IDLE;
              end else if (rdStep) begin
                beat_ff <= beat_ff + 4'h1;
              end
            end
            ST_WRITE: begin
              // A controller that stops strobing must not hang the channel
              if ((&laneDone) || (guard_ff == `DCH_WR_GUARD)) begin
                state_ff <= ST_IDLE;
              end else if (ckEdge) begin
                guard_ff <= guard_ff + 5'h01;
              end
            end
            default: begin
              state_ff <= ST_IDLE;
            end
          endcase
        end
      end

      // Each byte lane has its own strobe pair, flag line and store
      for (l = 0; l < `DCH_LANES; l = l + 1) begin : lane
        localparam P = c * `DCH_LANES + l;
        reg sLvl_ff;
        reg [3:0] wrCnt_ff;
        reg drive_ff;
        reg outT_ff;
        reg outC_ff;
        wire sT = dqsTF[l];
        wire sC = dqsCF[l];
        wire sPair = sT ^ sC;
        wire sEdge = sPair && (sT != sLvl_ff);
        // Controller strobe edge marks a beat whose data has already settled
        wire wrStep = (state_ff == ST_WRITE) && sEdge && (wrCnt_ff != `DCH_BEATS);
        wire [`DCH_COL_W-1:0] wrCol = col_ff + {7'h00, wrCnt_ff[`DCH_BEAT_W-1:0]};
        wire [AW-1:0] wrAddr = {bank_ff, rowSel, wrCol};

        assign laneDone[l] = (wrCnt_ff == `DCH_BEATS);

        // Incoming strobe level, tracked the same way as the clock pair
        always @(posedge clk) begin
          if (chRst) begin
            sLvl_ff <= 1'b0;
          end else if (sPair) begin
            sLvl_ff <= sT;
          end
        end

        // Write beat counter restarts with every write command
        always @(posedge clk) begin
          if (chRst || startAcc) begin
            wrCnt_ff <= 4'h0;
          end else if (wrStep) begin
            wrCnt_ff <= wrCnt_ff + 4'h1;
          end
        end

        // Read strobe toggles in the same cycle as the lane data changes;
        // the pair starts low as preamble and is released after the burst
        always @(posedge clk) begin
          if (chRst || scanF) begin
            drive_ff <= 1'b0;
            outT_ff <= 1'b0;
            outC_ff <= 1'b1;
          end else if (startRead) begin
            drive_ff <= 1'b1;
            outT_ff <= 1'b0;
            outC_ff <= 1'b1;
          end else if (rdStep) begin
            outT_ff <= ~outT_ff;
            outC_ff <= ~outC_ff;
          end else if (rdEnd) begin
            drive_ff <= 1'b0;
          end
        end

        dram_lane_store #(
          .AW(AW)
        ) u_store (
          .clk(clk),
          .rst(chRst),
          .wrEn(wrStep),
          .wrAddr(wrAddr),
          .wrByte(dqF[l*`DCH_LANE_W +: `DCH_LANE_W]),
          .wrFlag(dmiF[l]),
          .maskMode(maskF),
          .invEnable(invF),
          .rdEn(rdStep),
          .rdAddr(rdAddr),
          .rdByte(dqOut[P*`DCH_LANE_W +: `DCH_LANE_W]),
          .rdFlag(maskInvertOut[P])
        );

        // Data, strobe and flag share one enable so they release together
        assign dqOe[P] = drive_ff;
        assign dqsOe[P] = drive_ff;
        assign maskInvertOe[P] = drive_ff;
        assign dqsTrueOut[P] = outT_ff;
        assign dqsCompOut[P] = outC_ff;
      end
    end
  endgenerate

endmodule // dram_channel_data_address

// ### dram_channel_data_address_bench.sv
// Self-checking bench for one channel: write, read back, scan and die reset.
// Assumes the controller model owns the link clock and resolves no pins itself.
module dram_channel_data_address_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CHANNELS = 1;
  logic clk = 1'b0;
  logic rst_n, dieReset_n, scanEnablePin, inversionEnable, maskMode, lastT;
  wire clockTrue, clockComplement, cmdActivate, cmdRead, cmdWrite, scanActive;
  wire [2:0] bankSelectBits;
  wire [13:0] rowSelectBits;
  wire [7:0] columnSelectBits;
  wire [15:0] dqOut, ctlDq, dqWire;
  wire [1:0] dqOe, dqsTrueOut, dqsCompOut, dqsOe, maskInvertOut, maskInvertOe;
  wire [1:0] ctlFlag, ctlDqsTrue, ctlDqsComp, dqsTWire, dqsCWire, flagWire;
  logic [15:0] refMem [8];
  logic [17:0] beatQ [$];
  int bad_count = 0;
  int n_tests = 0;

  always #2 clk = ~clk;

  // Shared pins: whoever enables a lane owns its wire
  assign dqWire = {dqOe[1] ? dqOut[15:8] : ctlDq[15:8], dqOe[0] ? dqOut[7:0] : ctlDq[7:0]};
  assign dqsTWire = (dqsOe & dqsTrueOut) | (~dqsOe & ctlDqsTrue);
  assign dqsCWire = (dqsOe & dqsCompOut) | (~dqsOe & ctlDqsComp);
  assign flagWire = (maskInvertOe & maskInvertOut) | (~maskInvertOe & ctlFlag);

  dram_channel_data_address i_dram_channel_data_address (.clk(clk), .rst_n(rst_n),
    .dieReset_n(dieReset_n), .scanEnablePin(scanEnablePin), .clockTrue(clockTrue),
    .clockComplement(clockComplement), .cmdActivate(cmdActivate), .cmdRead(cmdRead),
    .cmdWrite(cmdWrite), .bankSelectBits(bankSelectBits), .rowSelectBits(rowSelectBits),
    .columnSelectBits(columnSelectBits), .inversionEnable(inversionEnable),
    .maskMode(maskMode), .dqIn(dqWire), .dqOut(dqOut), .dqOe(dqOe), .dqsTrueIn(dqsTWire),
    .dqsCompIn(dqsCWire), .dqsTrueOut(dqsTrueOut), .dqsCompOut(dqsCompOut), .dqsOe(dqsOe),
    .maskInvertIn(flagWire), .maskInvertOut(maskInvertOut), .maskInvertOe(maskInvertOe),
    .scanActive(scanActive));

  dram_ctrl_model i_dram_ctrl_model (.clk(clk), .clockTrue(clockTrue),
    .clockComplement(clockComplement), .cmdActivate(cmdActivate), .cmdRead(cmdRead),
    .cmdWrite(cmdWrite), .bankSelectBits(bankSelectBits), .rowSelectBits(rowSelectBits),
    .columnSelectBits(columnSelectBits), .ctlDq(ctlDq), .ctlFlag(ctlFlag),
    .ctlDqsTrue(ctlDqsTrue), .ctlDqsComp(ctlDqsComp));

  // Each read strobe toggle of lane 0 carries one beat of both lanes
  always @(negedge clk) begin
    if (dqsOe[0] && dqsTrueOut[0] !== lastT) beatQ.push_back({maskInvertOut, dqOut});
    lastT = dqsTrueOut[0];
  end

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Packed enables and idle levels; released channel reads 18'h00300
  function automatic logic [17:0] pins();
    return {dqOe, dqsOe, maskInvertOe, dqsTrueOut, dqsCompOut, maskInvertOut, scanActive, 5'h0};
  endfunction

  // Expected read beat: heavy bytes go out inverted with the flag high when coding is on
  function automatic logic [17:0] exp_beat(input logic [15:0] s, input logic inv);
    logic [17:0] e;
    e = {2'h0, s};
    for (int l = 0; l < 2; l++) begin
      if (inv && $countones(s[l*8 +: 8]) > 4) begin
        e[l*8 +: 8] = ~s[l*8 +: 8];
        e[16+l] = 1'b1;
      end
    end
    return e;
  endfunction

  task automatic set_modes(input logic inv, input logic msk);
    inversionEnable = inv;
    maskMode = msk;
    repeat (10) @(negedge clk);
  endtask

  // Write one burst at bank 3, column 8'h05 and keep the reference copy in step
  task automatic do_write(input logic [15:0] base, input logic [1:0] fl);
    logic [15:0] d;
    logic [1:0] f;
    i_dram_ctrl_model.issue(1'b0, 1'b1, 1'b0, 3'h3, 14'h0001, 8'h05);
    i_dram_ctrl_model.drive(1'b1);
    for (int n = 0; n < 8; n++) begin
      d = base + 16'h1357 * 16'(n);
      f = fl ^ 2'(n);
      i_dram_ctrl_model.beat(d, f);
      for (int l = 0; l < 2; l++) begin
        if (!(maskMode && f[l]))
          refMem[n][l*8 +: 8] = (inversionEnable && f[l]) ? ~d[l*8 +: 8] : d[l*8 +: 8];
      end
    end
    i_dram_ctrl_model.drive(1'b0);
  endtask

  task automatic do_read(input logic inv);
    int w;
    beatQ.delete();
    i_dram_ctrl_model.issue(1'b1, 1'b0, 1'b0, 3'h3, 14'h0001, 8'h05);
    i_dram_ctrl_model.edges(8);
    w = 0;
    while (beatQ.size() < 8 && w < 100) begin
      @(negedge clk);
      w++;
    end
    if (beatQ.size() < 8) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, beatQ.size(), 8);
      final_report();
    end
    for (int n = 0; n < 8; n++) check(beatQ[n], exp_beat(refMem[n], inv));
  endtask

  task automatic t_reset();
    check(pins(), 18'h00300);
    check({2'h0, dqOut}, 18'h00000);
  endtask

  task automatic t_invert();
    set_modes(1'b1, 1'b0);
    i_dram_ctrl_model.issue(1'b0, 1'b0, 1'b1, 3'h3, 14'h0001, 8'h00);
    do_write(16'hf0a5, 2'h1);
    do_read(1'b1);
  endtask

  task automatic t_mask();
    set_modes(1'b1, 1'b1);
    do_write(16'h3c0f, 2'h2);
    do_read(1'b0);
  endtask

  task automatic t_invert_off();
    set_modes(1'b0, 1'b0);
    do_write(16'hffe7, 2'h3);
    do_read(1'b0);
  endtask

  // A write that never sees a strobe must time out and leave the channel free
  task automatic t_guard();
    i_dram_ctrl_model.issue(1'b0, 1'b1, 1'b0, 3'h3, 14'h0001, 8'h05);
    i_dram_ctrl_model.edges(24);
    do_read(1'b0);
  endtask

  // Scan high: a read is refused and no lane is driven
  task automatic t_scan();
    scanEnablePin = 1'b1;
    repeat (10) @(negedge clk);
    beatQ.delete();
    i_dram_ctrl_model.issue(1'b1, 1'b0, 1'b0, 3'h3, 14'h0001, 8'h05);
    i_dram_ctrl_model.edges(8);
    check(pins(), 18'h00320);
    check(18'(beatQ.size()), 18'h00000);
    scanEnablePin = 1'b0;
    repeat (10) @(negedge clk);
  endtask

  // Die reset clears the channel but not the stored array
  task automatic t_die_reset();
    dieReset_n = 1'b0;
    repeat (10) @(negedge clk);
    check(pins(), 18'h00300);
    dieReset_n = 1'b1;
    repeat (10) @(negedge clk);
    // Open rows were cleared too, so the row is opened again first
    i_dram_ctrl_model.issue(1'b0, 1'b0, 1'b1, 3'h3, 14'h0001, 8'h00);
    do_read(1'b0);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    dieReset_n = 1'b1;
    scanEnablePin = 1'b0;
    inversionEnable = 1'b0;
    maskMode = 1'b0;
    lastT = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_invert();
    t_mask();
    t_invert_off();
    t_guard();
    t_scan();
    t_die_reset();
    final_report();
  end
endmodule // dram_channel_data_address_bench

bind dram_channel_data_address dram_channel_checker #(.CHANNELS(CHANNELS)) i_dram_channel_checker (
  .clk(clk), .rst_n(rst_n), .dieReset_n(dieReset_n), .scanEnablePin(scanEnablePin),
  .inversionEnable(inversionEnable), .maskMode(maskMode), .dqOut(dqOut), .dqOe(dqOe),
  .dqsTrueOut(dqsTrueOut), .dqsCompOut(dqsCompOut), .dqsOe(dqsOe),
  .maskInvertOut(maskInvertOut), .maskInvertOe(maskInvertOe), .scanActive(scanActive));

// ### dram_channel_regs.vh
// Shared constants of the channel data path: widths, address split, burst figures.
// Included by the channel top and by the byte-lane store; holds definitions only.
`ifndef DRAM_CHANNEL_REGS_VH
`define DRAM_CHANNEL_REGS_VH

// Data bus organisation per channel
`define DCH_DQ_W 16
`define DCH_LANE_W 8
`define DCH_LANES 2

// Address split: bank, row, full column, column bits actually sent
`define DCH_BANK_W 3
`define DCH_BANKS 8
`define DCH_ROW_W 14
`define DCH_COL_W 10
`define DCH_COLSENT_W 8
`define DCH_COL_ZERO 2'h0

// Half-cycle beats per access and the last beat index width
`define DCH_BEATS 4'h8
`define DCH_BEAT_W 3

// Inversion kicks in when a byte holds more ones than this
`define DCH_INV_LIMIT 4'h4

// Link clock edges a write burst may take before it is abandoned
`define DCH_WR_GUARD 5'h18

// Channel state codes
`define DCH_ST_IDLE 2'h0
`define DCH_ST_READ 2'h1
`define DCH_ST_WRITE 2'h2

`endif

// ### dram_ctrl_model.sv
// Memory controller model: link clock, decoded commands, write strobes and data.
// Assumes its tasks are called from one process, entered and left on a falling clk edge.
`include "dram_channel_regs.vh"

module dram_ctrl_model (
  input wire clk,
  output logic clockTrue,
  output logic clockComplement,
  output logic cmdActivate,
  output logic cmdRead,
  output logic cmdWrite,
  output logic [`DCH_BANK_W-1:0] bankSelectBits,
  output logic [`DCH_ROW_W-1:0] rowSelectBits,
  output logic [`DCH_COLSENT_W-1:0] columnSelectBits,
  output logic [`DCH_DQ_W-1:0] ctlDq,
  output logic [`DCH_LANES-1:0] ctlFlag,
  output logic [`DCH_LANES-1:0] ctlDqsTrue,
  output logic [`DCH_LANES-1:0] ctlDqsComp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv;

  // Link clock stands low between frames; strobes park at the low preamble level
  initial begin
    {clockTrue, cmdActivate, cmdRead, cmdWrite, drv} = 5'h0;
    clockComplement = 1'b1;
    {bankSelectBits, rowSelectBits, columnSelectBits} = 25'h0;
    {ctlDq, ctlFlag, ctlDqsTrue} = 20'h0;
    ctlDqsComp = 2'h3;
  end

  // Released data and flag lines wander so stale values never look valid
  always @(negedge clk) begin
    if (!drv) begin
      ctlDq <= ~ctlDq;
      ctlFlag <= ~ctlFlag;
    end
  end

  task automatic edges(input int n);
    repeat (n) begin
      clockTrue <= ~clockTrue;
      clockComplement <= clockTrue;
      repeat (6) @(negedge clk);
    end
  endtask

  // Command held 6 clk either side of the rising crossing; column bits 1:0 never sent
  task automatic issue(input logic rd, input logic wr, input logic act, input logic [2:0] b,
                       input logic [13:0] r, input logic [7:0] c);
    {cmdRead, cmdWrite, cmdActivate} <= {rd, wr, act};
    {bankSelectBits, rowSelectBits, columnSelectBits} <= {b, r, c};
    repeat (6) @(negedge clk);
    edges(1);
    {cmdRead, cmdWrite, cmdActivate} <= 3'h0;
    edges(1);
  endtask

  task automatic drive(input logic on);
    drv <= on;
    @(negedge clk);
  endtask

  // One beat: both lanes' data and flag first, then each lane's own strobe edge
  task automatic beat(input logic [15:0] d, input logic [1:0] f);
    ctlDq <= d;
    ctlFlag <= f;
    repeat (6) @(negedge clk);
    ctlDqsTrue <= ~ctlDqsTrue;
    ctlDqsComp <= ctlDqsTrue;
    repeat (6) @(negedge clk);
  endtask
endmodule // dram_ctrl_model

// ### dram_lane_store.v
// One byte lane of storage with mask coding on writes and inversion coding on both directions.
// Assumes the channel top sequences beats; read data is registered on rdEn.
`include "dram_channel_regs.vh"

module dram_lane_store #(
  parameter AW = 15
) (
  input wire clk,
  input wire rst,
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [`DCH_LANE_W-1:0] wrByte,
  input wire wrFlag,
  input wire maskMode,
  input wire invEnable,
  input wire rdEn,
  input wire [AW-1:0] rdAddr,
  output wire [`DCH_LANE_W-1:0] rdByte,
  output wire rdFlag
);

  reg [`DCH_LANE_W-1:0] cells [0:(1<<AW)-1];
  reg [`DCH_LANE_W-1:0] rdByte_ff;
  reg rdFlag_ff;

  // Count of ones in a byte, used to pick the cheaper polarity
  function [3:0] onesOf;
    input [`DCH_LANE_W-1:0] b;
    integer k;
    begin
      onesOf = 4'h0;
      for (k = 0; k < `DCH_LANE_W; k = k + 1) begin
        onesOf = onesOf + {3'h0, b[k]};
      end
    end
  endfunction

  // Mask mode turns inversion off for both directions
  wire invActive = invEnable && !maskMode;
  wire [`DCH_LANE_W-1:0] rawRd = cells[rdAddr];
  wire invRd = invActive && (onesOf(rawRd) > `DCH_INV_LIMIT);

  // Masked bytes leave the cell untouched; inverted bytes are restored
  always @(posedge clk) begin
    if (wrEn && !(maskMode && wrFlag)) begin
      cells[wrAddr] <= (invActive && wrFlag) ? ~wrByte : wrByte;
    end
  end

  // Flag high marks an inverted byte, low a plain one
  always @(posedge clk) begin
    if (rst) begin
      rdByte_ff <= {`DCH_LANE_W{1'b0}};
      rdFlag_ff <= 1'b0;
    end else if (rdEn) begin
      rdByte_ff <= invRd ? ~rawRd : rawRd;
      rdFlag_ff <= invRd;
    end
  end

  assign rdByte = rdByte_ff;
  assign rdFlag = rdFlag_ff;

endmodule // dram_lane_store

// ### dram_pin_sync.v
// Three-stage pin synchroniser with agreement filter, any width.
// Assumes each bit is asynchronous to clk; a bit changes only when stages 2 and 3 agree.
module dram_pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] pinOut
);

  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;
  reg [WIDTH-1:0] stage3_ff;
  reg [WIDTH-1:0] agreed_ff;

  // Stage 1 feeds only stage 2, so metastability never reaches logic
  wire [WIDTH-1:0] agree = ~(stage2_ff ^ stage3_ff);

  // A glitch shorter than one stage is ignored by the agreement filter
  always @(posedge clk) begin
    if (!rst_n) begin
      stage1_ff <= INIT;
      stage2_ff <= INIT;
      stage3_ff <= INIT;
      agreed_ff <= INIT;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      agreed_ff <= (stage3_ff & agree) | (agreed_ff & ~agree);
    end
  end

  assign pinOut = agreed_ff;

endmodule // dram_pin_sync
